/* hw/epvs_pkg.sv */
// Package for the EPROM program/verify sequencer.
// Assumes a 100 MHz system clock; all pin levels are logic-level abstractions.
package epvs_pkg;
	localparam int unsigned ADDR_W         = 10;
	localparam int unsigned DATA_W         = 8;
	localparam int unsigned XTAL_PER_MC    = 15;
	localparam int unsigned ALE_HIGH_EDGES = 3;
	localparam int unsigned DATA_OUT_MC    = 4;
	localparam logic [7:0]  ERASED_BYTE    = 8'h00;
	localparam logic [7:0]  BUS_RESET      = 8'h00;
	localparam logic [3:0]  XCNT_RESET     = 4'h0;
	localparam logic [2:0]  DLY_RESET      = 3'h0;
	localparam int unsigned SYNC_W         = 16;

	typedef enum logic [1:0]
	{
		EPVS_OFF,
		EPVS_PGM,
		EPVS_VWAIT,
		EPVS_VERIFY
	} epvs_mode_t;
endpackage : epvs_pkg

/* hw/epvs_sequencer.sv */
// Device-side program/verify access path of an on-chip EPROM.
// Assumes all pins are asynchronous to clock; the crystal input runs well below 50 MHz.
//
// Notes on behaviour
// - Mode-select low with enable and reset high selects program mode.
// - Rising reset in program or verify mode latches the address.
// - Mode-select high, power back to normal, switches device into verify mode.
// - In verify mode the stored byte at the latched address drives the bus.
// - Device pulses its address-latch strobe output once per machine cycle.
// - With mode-select high, rising reset starts the data-out delay.
`timescale 1ns/10ps
module epvs_sequencer
	import epvs_pkg::*;
#(
	parameter int unsigned DEPTH = 1024
)
(
	input  wire logic                        clock,
	input  wire logic                        nrst,
	input  wire logic                        crystal_clock_input,
	input  wire logic                        mode_select,
	input  wire logic                        program_mode_enable,
	input  wire logic                        reset_pin_n,
	input  wire logic                        program_power,
	input  wire logic                        program_pulse_strobe,
	input  wire logic [epvs_pkg::DATA_W-1:0] bus_in,
	output logic      [epvs_pkg::DATA_W-1:0] bus_out,
	output logic                             bus_oe,
	input  wire logic [1:0]                  upper_address_lines,
	output logic                             addr_latch_strobe
);
	import epvs_pkg::*;

	logic [SYNC_W-1:0] s1_reg;
	logic [SYNC_W-1:0] s2_reg;
	logic [SYNC_W-1:0] s3_reg;
	logic              xt_rise;
	logic              rst_rise;
	logic              mode_rise;
	logic              stb_fall;
	logic              mode_s;
	logic              en_s;
	logic              rst_s;
	logic              pwr_s;
	logic [DATA_W-1:0] bus_s;
	logic [ADDR_W-1:0] addr_s;
	logic [3:0]        xcnt_reg;
	logic [3:0]        xcnt_next;
	logic              ale_reg;
	logic              ale_next;
	logic              mc_tick;
	epvs_mode_t        mode_reg;
	epvs_mode_t        mode_next;
	logic [2:0]        dly_reg;
	logic [2:0]        dly_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [DATA_W-1:0] dout_reg;
	logic [DATA_W-1:0] dout_next;
	logic              wr_en;
	logic [DATA_W-1:0] mem_reg [DEPTH];

	// Two-stage synchroniser; third stage only feeds edge detection
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			s1_reg <= {crystal_clock_input, mode_select, program_mode_enable, reset_pin_n,
				program_power, program_pulse_strobe, upper_address_lines, bus_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign xt_rise   = s2_reg[15] & ~s3_reg[15];
	assign mode_s    = s2_reg[14];
	assign en_s      = s2_reg[13];
	assign rst_s     = s2_reg[12];
	assign pwr_s     = s2_reg[11];
	assign mode_rise = s2_reg[14] & ~s3_reg[14];
	assign rst_rise  = s2_reg[12] & ~s3_reg[12];
	assign stb_fall  = ~s2_reg[10] & s3_reg[10];
	assign addr_s    = s2_reg[9:0];
	assign bus_s     = s2_reg[7:0];

	// Machine cycle from crystal edges; ALE marks each cycle
	always_comb
	begin
		xcnt_next = xcnt_reg;
		mc_tick   = 1'b0;
		if (xt_rise)
		begin
			if (xcnt_reg == 4'(XTAL_PER_MC - 1))
			begin
				xcnt_next = XCNT_RESET;
				mc_tick   = 1'b1;
			end
			else
				xcnt_next = xcnt_reg + 4'h1;
		end
		ale_next = (xcnt_next < 4'(ALE_HIGH_EDGES));
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			xcnt_reg <= XCNT_RESET;
			ale_reg  <= 1'b0;
		end
		else
		begin
			xcnt_reg <= xcnt_next;
			ale_reg  <= ale_next;
		end
	end

	assign addr_latch_strobe = ale_reg;

	// Mode sequencing, address latch, data-out delay
	always_comb
	begin
		mode_next = mode_reg;
		dly_next  = dly_reg;
		addr_next = addr_reg;
		dout_next = dout_reg;
		wr_en     = 1'b0;
		if (en_s && rst_rise)
			addr_next = addr_s;
		if (!en_s || !rst_s)
		begin
			mode_next = EPVS_OFF;
			dly_next  = DLY_RESET;
		end
		else if (!mode_s)
			mode_next = EPVS_PGM;
		else if (rst_rise || mode_rise || mode_reg == EPVS_OFF || mode_reg == EPVS_PGM)
		begin
			// Delay restarts on either trigger so stale data never shows
			mode_next = EPVS_VWAIT;
			dly_next  = DLY_RESET;
		end
		else if (mode_reg == EPVS_VWAIT && mc_tick)
		begin
			if (dly_reg == 3'(DATA_OUT_MC - 1))
			begin
				mode_next = EPVS_VERIFY;
				dout_next = mem_reg[addr_reg];
			end
			else
				dly_next = dly_reg + 3'h1;
		end
		// Write only on a completed strobe pulse under programming power
		if (mode_reg == EPVS_PGM && !mode_s && pwr_s && stb_fall)
			wr_en = 1'b1;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_reg <= EPVS_OFF;
			dly_reg  <= DLY_RESET;
			addr_reg <= '0;
			dout_reg <= BUS_RESET;
		end
		else
		begin
			mode_reg <= mode_next;
			dly_reg  <= dly_next;
			addr_reg <= addr_next;
			dout_reg <= dout_next;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_mem
			always_ff @(posedge clock or negedge nrst)
			begin
				if (!nrst)
					mem_reg[gi] <= ERASED_BYTE;
				else if (wr_en && addr_reg == ADDR_W'(gi))
					mem_reg[gi] <= bus_s;
			end
		end
	endgenerate

	assign bus_out = dout_reg;
	assign bus_oe  = (mode_reg == EPVS_VERIFY);

	property p_addr_latch;
		@(posedge clock) disable iff (!nrst)
		(en_s && rst_rise) |=> (addr_reg == $past(addr_s));
	endproperty
	a_addr_latch: assert property (p_addr_latch) else $error("address not latched");

	property p_pgm_no_drive;
		@(posedge clock) disable iff (!nrst)
		(en_s && rst_s && !mode_s) |=> (mode_reg == EPVS_PGM) && !bus_oe;
	endproperty
	a_pgm_no_drive: assert property (p_pgm_no_drive) else $error("program mode wrong");

	property p_write;
		@(posedge clock) disable iff (!nrst)
		(mode_reg == EPVS_PGM && !mode_s && pwr_s && stb_fall)
			|=> (mem_reg[addr_reg] == $past(bus_s));
	endproperty
	a_write: assert property (p_write) else $error("byte not written");

	property p_verify_mode;
		@(posedge clock) disable iff (!nrst)
		(mode_reg == EPVS_VWAIT || mode_reg == EPVS_VERIFY) |-> $past(mode_s) && $past(en_s);
	endproperty
	a_verify_mode: assert property (p_verify_mode) else $error("verify without mode");

	property p_verify_data;
		@(posedge clock) disable iff (!nrst)
		$rose(bus_oe) |-> (bus_out == mem_reg[addr_reg]) && $past(mc_tick);
	endproperty
	a_verify_data: assert property (p_verify_data) else $error("wrong verify byte");

	property p_delay;
		@(posedge clock) disable iff (!nrst)
		(en_s && rst_s && mode_s && rst_rise) |=> (mode_reg == EPVS_VWAIT) && (dly_reg == 3'h0);
	endproperty
	a_delay: assert property (p_delay) else $error("delay not restarted");

	property p_ale;
		@(posedge clock) disable iff (!nrst)
		// Rising edge, not a level, so a stuck-high strobe is caught too
		mc_tick |=> $rose(ale_reg);
	endproperty
	a_ale: assert property (p_ale) else $error("ALE missing");

	c_write: cover property (@(posedge clock) disable iff (!nrst) wr_en);
	c_verify: cover property (@(posedge clock) disable iff (!nrst) $rose(bus_oe));
	c_relatch: cover property (@(posedge clock) disable iff (!nrst)
		(mode_reg == EPVS_VERIFY) ##1 (mode_reg == EPVS_PGM));
endmodule : epvs_sequencer

/* bench/epvs_program_pulse_strobe.sv */
// Behavioural programmer that steps the sequencer's pins word by word.
// Assumes the bench resolves the shared bus from both enables.
`timescale 1ns/10ps
module epvs_pgmr
	import epvs_pkg::*;
(
	input  wire logic                      clock,
	output logic                           crystal_clock_input,
	output logic                           mode_select,
	output logic                           program_mode_enable,
	output logic                           reset_pin_n,
	output logic                           program_power,
	output logic                           program_pulse_strobe,
	output logic [epvs_pkg::DATA_W-1:0]    bus_drv,
	output logic                           bus_drv_oe,
	output logic [1:0]                     upper_address_lines
);
	import epvs_pkg::*;
	// Stands for 50 to 60 ms; the device does not time the pulse
	localparam int PULSE = 1000;
	localparam int STEP  = 1000;
	logic tgl = 1'b0;
	logic stb_drv;
	logic stb_val;
	// Floating strobe toggles so a stray sample cannot look clean
	assign program_pulse_strobe = stb_drv ? stb_val : tgl;
	always @(posedge clock) tgl <= ~tgl;
	initial
	begin
		reset_pin_n = 1'b0;
		mode_select = 1'b1;
		program_mode_enable = 1'b0;
		program_power = 1'b0;
		bus_drv = 8'h00;
		bus_drv_oe = 1'b0;
		upper_address_lines = 2'h0;
		stb_drv = 1'b0;
		stb_val = 1'b0;
		crystal_clock_input = 1'b0;
		forever #80 crystal_clock_input = ~crystal_clock_input;
	end
	task automatic step();
		repeat (STEP) @(posedge clock);
	endtask : step
	task automatic enter();
		mode_select <= 1'b0;
		step();
		program_mode_enable <= 1'b1;
		step();
	endtask : enter
	// One whole word, verify included, before the next address
	task automatic word(input logic [9:0] a, input logic [7:0] d, input logic pwr,
		input logic ro);
		mode_select <= ro;
		bus_drv <= a[7:0];
		upper_address_lines <= a[9:8];
		bus_drv_oe <= 1'b1;
		step();
		reset_pin_n <= 1'b1;
		step();
		if (!ro)
		begin
			bus_drv <= d;
			stb_drv <= 1'b1;
			step();
			program_power <= pwr;
			step();
			stb_val <= 1'b1;
			repeat (PULSE) @(posedge clock);
			stb_val <= 1'b0;
			step();
			program_power <= 1'b0;
			step();
			stb_drv <= 1'b0;
			mode_select <= 1'b1;
		end
		bus_drv_oe <= 1'b0;
		step();
		step();
		mode_select <= 1'b0;
		step();
		reset_pin_n <= 1'b0;
		step();
	endtask : word
	task automatic leave();
		program_mode_enable <= 1'b0;
		mode_select <= 1'b1;
		step();
	endtask : leave
endmodule : epvs_pgmr

/* bench/tb_epvs_sequencer.sv */
// Self-checking bench for the program/verify sequencer.
// Assumes a 100 MHz clock and the programmer model beside it.
`timescale 1ns/10ps
module tb_epvs_sequencer;
	import epvs_pkg::*;
	logic clock, nrst, crystal_clock_input, mode_select, program_mode_enable;
	logic reset_pin_n, program_power, program_pulse_strobe, bus_oe, bus_drv_oe;
	logic addr_latch_strobe, oe_q, a_q;
	logic [7:0] bus_in, bus_out, bus_drv, d;
	logic [7:0] flt = 8'h5a;
	logic [7:0] mem [0:1023];
	logic [7:0] exp_q [$];
	logic [1:0] upper_address_lines;
	logic [1:0] pv = 2'h3;
	logic [9:0] a;
	int err_total, num_checks, n, h;
	int dly = 0;
	epvs_sequencer epvs_sequencer_i (.clock, .nrst, .crystal_clock_input, .mode_select,
		.program_mode_enable, .reset_pin_n, .program_power, .program_pulse_strobe,
		.bus_in, .bus_out, .bus_oe, .upper_address_lines, .addr_latch_strobe);
	epvs_pgmr epvs_pgmr_i (.clock, .crystal_clock_input, .mode_select,
		.program_mode_enable, .reset_pin_n, .program_power, .program_pulse_strobe,
		.bus_drv, .bus_drv_oe, .upper_address_lines);
	// Undriven bus wanders so stale data cannot pass
	assign bus_in = bus_oe ? bus_out : (bus_drv_oe ? bus_drv : flt);
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge clock)
	begin
		flt <= flt + 8'h01;
		pv <= {mode_select, reset_pin_n};
		oe_q <= bus_oe;
		dly <= (({mode_select, reset_pin_n} & ~pv) != 2'h0) ? 0 : dly + 1;
		if (bus_oe && !oe_q)
		begin
			check("verify data", bus_out, exp_q.pop_front());
			check("data delay", 8'(dly > 720 && dly < 980), 8'h01);
		end
	end
	initial
	begin
		#900000;
		err_total++;
		give_verdict();
	end
	initial
	begin
		nrst = 1'b0;
		foreach (mem[i]) mem[i] = ERASED_BYTE;
		void'($urandom(25692));
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
		a_q = addr_latch_strobe;
		n = 0;
		h = 0;
		repeat (1200)
		begin
			@(posedge clock);
			n += int'(addr_latch_strobe && !a_q);
			h += int'(addr_latch_strobe);
			a_q = addr_latch_strobe;
		end
		check("ale rises", 8'(n), 8'h05);
		check("ale high", 8'(h), 8'hf0);
		epvs_pgmr_i.enter();
		for (int i = 0; i < 4; i++)
		begin
			a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
			d = 8'($urandom);
			mem[a] = d;
			exp_q.push_back(d);
			epvs_pgmr_i.word(a, d, 1'b1, 1'b0);
			check("bus released", 8'(bus_oe), 8'h00);
		end
		// Pulse without programming power must leave the word alone
		exp_q.push_back(mem[10'h3ff]);
		epvs_pgmr_i.word(10'h3ff, ~mem[10'h3ff], 1'b0, 1'b0);
		check("bus released", 8'(bus_oe), 8'h00);
		// Mid-run reset returns the array to the erased value
		nrst <= 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		foreach (mem[j]) mem[j] = ERASED_BYTE;
		repeat (5) @(posedge clock);
		// Verify only: reset rises while mode-select already high
		exp_q.push_back(mem[10'h000]);
		epvs_pgmr_i.word(10'h000, 8'h00, 1'b0, 1'b1);
		check("bus released", 8'(bus_oe), 8'h00);
		epvs_pgmr_i.leave();
		check("pending reads", 8'(exp_q.size()), 8'h00);
		give_verdict();
	end
endmodule : tb_epvs_sequencer
